// file: rtl/pci_pm_capability_regs.sv
// read-only configuration registers for the power-management capability entry
`timescale 1ns/100ps
module pci_pm_capability_regs
#(
    parameter bit PRINTED_WORD_MODE = 1'b0    // 1 returns the printed whole-word values
)
(
    input  wire logic                 clk,            // configuration clock
    input  wire logic                 reset,          // synchronous, active high
    input  wire logic                 aux_power_pin,  // auxiliary supply present, asynchronous
    input  wire pm_cap_pkg::cfg_req_s cfg_req,        // configuration request
    output pm_cap_pkg::cfg_rsp_s      cfg_rsp,        // registered answer
    output logic                      aux_power_q,    // filtered auxiliary level
    output logic [15:0]               pm_word_q       // capabilities word as currently reported
);

    // true when the request addresses the dword at the given byte offset
    function automatic logic dword_hit(input logic [5:0] idx, input logic [7:0] offset);
        dword_hit = (idx == offset[7:2]);
    endfunction

    logic        aux_level;      // synchronised pin level
    logic [15:0] cap_word;       // current capabilities word
    logic        hit_cap_ptr;    // header pointer dword
    logic        hit_bus_acc;    // latency dword
    logic        hit_pm_entry;   // capability entry dword
    logic        any_hit;        // address belongs here
    logic [31:0] lane_mask;      // byte enables widened to bits
    logic [31:0] raw_rdata;      // unmasked read data
    logic [31:0] read_value;     // masked read data
    pm_cap_pkg::cfg_rsp_s rsp_d; // next answer
    pm_cap_pkg::cfg_rsp_s rsp_q; // answer register
    logic [15:0] pm_word_d;      // next reported word

    // the supply pin may move at any time; filter it before use
    pin_level_sync u_aux_sync
    (
        .clk       (clk),
        .reset     (reset),
        .pin_async (aux_power_pin),
        .level_q   (aux_level)
    );

    // word contents follow the filtered supply level
    pm_capability_word #(.PRINTED_WORD_MODE(PRINTED_WORD_MODE)) u_cap_word
    (
        .aux_present (aux_level),
        .cap_word    (cap_word)
    );

    // address decode
    assign hit_cap_ptr  = dword_hit(cfg_req.dword, pm_cap_pkg::CAP_PTR_OFFSET);
    assign hit_bus_acc  = dword_hit(cfg_req.dword, pm_cap_pkg::BUS_ACCESS_OFFSET);
    assign hit_pm_entry = dword_hit(cfg_req.dword, pm_cap_pkg::PM_ENTRY_OFFSET);
    assign any_hit      = hit_cap_ptr | hit_bus_acc | hit_pm_entry;

    // widen byte enables so disabled lanes read zero
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{cfg_req.byte_en[lane]}};
        end
    endgenerate

    // read data; lanes owned by other header registers read zero here
    always_comb
    begin
        raw_rdata = 32'h0000_0000;
        if (hit_cap_ptr)
        begin
            raw_rdata[pm_cap_pkg::CAP_PTR_LANE*8 +: 8] = pm_cap_pkg::CAP_PTR_RESET;
        end
        else if (hit_bus_acc)
        begin
            raw_rdata[pm_cap_pkg::BUS_ACCESS_LANE*8 +: 8] = pm_cap_pkg::BUS_ACCESS_RESET;
        end
        else if (hit_pm_entry)
        begin
            raw_rdata[pm_cap_pkg::CAP_ID_LANE*8 +: 8]   = pm_cap_pkg::CAP_ID_RESET;
            raw_rdata[pm_cap_pkg::NEXT_PTR_LANE*8 +: 8] = pm_cap_pkg::NEXT_PTR_RESET;
            raw_rdata[pm_cap_pkg::PM_WORD_LSB +: 16]    = cap_word;
        end
    end

    // writes return no data and store nothing
    assign read_value = cfg_req.write ? 32'h0000_0000 : (raw_rdata & lane_mask);

    // every request, read or write, completes one cycle later
    always_comb
    begin
        rsp_d       = '0;
        rsp_d.ack   = cfg_req.valid;
        rsp_d.hit   = cfg_req.valid & any_hit;
        rsp_d.rdata = cfg_req.valid ? read_value : 32'h0000_0000;
    end

    assign pm_word_d = cap_word;

    // answer and status registers; no register here ever takes write data
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rsp_q     <= '0;
            pm_word_q <= 16'h0000;
        end
        else
        begin
            rsp_q     <= rsp_d;
            pm_word_q <= pm_word_d;
        end
    end

    assign cfg_rsp     = rsp_q;
    assign aux_power_q = aux_level;

endmodule // pci_pm_capability_regs

// file: rtl/pin_level_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_level_sync
(
    input  wire logic clk,         // core clock
    input  wire logic reset,       // synchronous, active high
    input  wire logic pin_async,   // raw pin level
    output logic      level_q      // filtered level
);

    logic meta_q;    // first stage, read only by second
    logic stage2_q;  // second stage
    logic stage3_q;  // third stage

    // shift chain; level follows only when stages two and three agree
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_q   <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
            level_q  <= 1'b0;
        end
        else
        begin
            meta_q   <= pin_async;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
            if (stage2_q == stage3_q)
            begin
                level_q <= stage3_q;
            end
        end
    end

endmodule // pin_level_sync

// file: rtl/pm_cap_pkg.sv
// constants and carriers for the power-management capability register bank
package pm_cap_pkg;

    // configuration byte offsets, always dword aligned here
    localparam logic [7:0] CAP_PTR_OFFSET     = 8'h34;  // dword holding the capability pointer, lane 0
    localparam logic [7:0] BUS_ACCESS_OFFSET  = 8'h3C;  // dword holding the latency request, lane 3
    localparam logic [7:0] PM_ENTRY_OFFSET    = 8'hDC;  // power-management capability entry

    // byte lanes inside the addressed dword
    localparam int CAP_PTR_LANE    = 0;
    localparam int BUS_ACCESS_LANE = 3;
    localparam int CAP_ID_LANE     = 0;
    localparam int NEXT_PTR_LANE   = 1;
    localparam int PM_WORD_LSB     = 16;                    // capabilities word in the upper half

    // fixed register contents
    localparam logic [7:0] BUS_ACCESS_RESET   = 8'h18;
    localparam logic [7:0] CAP_ID_RESET       = 8'h01;
    localparam logic [7:0] NEXT_PTR_RESET     = 8'h00;
    localparam logic [7:0] CAP_PTR_RESET      = 8'hDC;

    // capabilities word field positions, counted within the 16-bit word
    localparam int WAKE_MASK_LSB  = 11;  // five bits
    localparam int D2_SUPPORT_BIT = 10;
    localparam int D1_SUPPORT_BIT = 9;
    localparam int AUX_CUR_LSB    = 6;   // three bits
    localparam int DSI_BIT        = 5;
    localparam int RSVD_BIT       = 4;
    localparam int EVT_CLOCK_BIT  = 3;
    localparam int VERSION_LSB    = 0;   // three bits

    // capabilities word field values
    localparam logic [4:0] WAKE_MASK_AUX    = 5'h1F;
    localparam logic [4:0] WAKE_MASK_NO_AUX = 5'h03;
    localparam logic       D2_SUPPORT_VAL   = 1'b1;
    localparam logic       D1_SUPPORT_VAL   = 1'b1;
    localparam logic [2:0] AUX_CUR_VAL      = 3'h0;
    localparam logic       DSI_VAL          = 1'b1;
    localparam logic       RSVD_VAL         = 1'b0;
    localparam logic       EVT_CLOCK_VAL    = 1'b0;
    localparam logic [2:0] VERSION_VAL      = 3'h2;

    // whole-word values as printed, used only in printed-word mode
    localparam logic [15:0] PM_WORD_PRINTED_AUX    = 16'hFE21;
    localparam logic [15:0] PM_WORD_PRINTED_NO_AUX = 16'h7E21;

    // configuration request from the host side
    typedef struct packed {
        logic        valid;     // request present this cycle
        logic        write;     // 1 write, 0 read
        logic [5:0]  dword;     // byte address bits 7:2
        logic [3:0]  byte_en;   // active-high byte enables
        logic [31:0] wdata;     // write data, discarded
    } cfg_req_s;

    // registered answer
    typedef struct packed {
        logic        ack;       // one-cycle completion pulse
        logic        hit;       // address belongs to this bank
        logic [31:0] rdata;     // read data, zero on miss or write
    } cfg_rsp_s;

endpackage

// file: rtl/pm_capability_word.sv
// assembles the 16-bit power-management capabilities word
`timescale 1ns/100ps
module pm_capability_word
#(
    parameter bit PRINTED_WORD_MODE = 1'b0   // 1 returns the printed whole-word values
)
(
    input  wire logic        aux_present,    // filtered auxiliary power level
    output logic [15:0]      cap_word        // combinational capabilities word
);

    logic [15:0] field_word;    // word built field by field
    logic [15:0] printed_word;  // word as printed
    logic [4:0]  wake_mask;     // wake-capable states

    // wake states depend on auxiliary power
    assign wake_mask = aux_present ? pm_cap_pkg::WAKE_MASK_AUX : pm_cap_pkg::WAKE_MASK_NO_AUX;

    // field layout; every other field is a fixed constant
    always_comb
    begin
        field_word = 16'h0000;
        field_word[pm_cap_pkg::WAKE_MASK_LSB +: 5] = wake_mask;
        field_word[pm_cap_pkg::D2_SUPPORT_BIT]     = pm_cap_pkg::D2_SUPPORT_VAL;
        field_word[pm_cap_pkg::D1_SUPPORT_BIT]     = pm_cap_pkg::D1_SUPPORT_VAL;
        field_word[pm_cap_pkg::AUX_CUR_LSB +: 3]   = pm_cap_pkg::AUX_CUR_VAL;
        field_word[pm_cap_pkg::DSI_BIT]            = pm_cap_pkg::DSI_VAL;
        field_word[pm_cap_pkg::RSVD_BIT]           = pm_cap_pkg::RSVD_VAL;
        field_word[pm_cap_pkg::EVT_CLOCK_BIT]      = pm_cap_pkg::EVT_CLOCK_VAL;
        field_word[pm_cap_pkg::VERSION_LSB +: 3]   = pm_cap_pkg::VERSION_VAL;
    end

    // printed values disagree with the field layout, so both are offered
    assign printed_word = aux_present ? pm_cap_pkg::PM_WORD_PRINTED_AUX
                                      : pm_cap_pkg::PM_WORD_PRINTED_NO_AUX;

    assign cap_word = PRINTED_WORD_MODE ? printed_word : field_word;

endmodule // pm_capability_word

// file: verification/pci_pm_capability_regs_tb_top.sv
// testbench for the power-management capability register bank
`timescale 1ns/100ps
module pci_pm_capability_regs_tb_top;
    logic                 clk;             // 250 MHz
    logic                 reset;           // synchronous, active high
    logic                 aux_power_pin;   // supply level
    pm_cap_pkg::cfg_req_s cfg_req;         // from host model
    pm_cap_pkg::cfg_rsp_s cfg_rsp;         // from the bank
    logic                 aux_power_q;     // filtered supply
    logic [15:0]          pm_word_q;       // reported word
    int                   error_cnt = 0;   // mismatches
    int                   num_checks = 0;  // comparisons
    int                   cycles = 0;      // hang guard
    logic [31:0]          rd;              // last read data
    logic                 hit;             // last hit flag
    logic                 ok;              // last ack seen
    pci_pm_capability_regs dut (.clk(clk), .reset(reset), .aux_power_pin(aux_power_pin), .cfg_req(cfg_req),
                                .cfg_rsp(cfg_rsp), .aux_power_q(aux_power_q), .pm_word_q(pm_word_q));
    pm_cfg_host host (.clk(clk), .req(cfg_req), .rsp(cfg_rsp));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // built from the field table, not from the printed whole words
    function automatic logic [15:0] word_exp(input logic aux);
        return {aux ? 5'h1F : 5'h03, 1'b1, 1'b1, 3'h0, 1'b1, 1'b0, 1'b0, 3'h2};
    endfunction
    // one access; every request must complete
    task automatic go(input logic wr, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] exp);
        host.access(wr, dw, be, rd, hit, ok);
        check("ack", {31'h0, ok}, 32'h1);
        check("rdata", rd, exp);
    endtask
    // header pointer, with hit, and latency byte
    task automatic t_header;
        go(1'b0, 6'h0D, 4'hF, 32'h0000_00DC);
        check("hit", {31'h0, hit}, 32'h1);
        go(1'b0, 6'h0F, 4'hF, 32'h1800_0000);
    endtask
    // whole entry for one supply level, after the filter settles
    task automatic t_entry(input logic aux);
        aux_power_pin = aux;
        repeat (8) @(posedge clk);
        #1;
        check("aux", {31'h0, aux_power_q}, {31'h0, aux});
        check("word", {16'h0, pm_word_q}, {16'h0, word_exp(aux)});
        go(1'b0, 6'h37, 4'hF, {word_exp(aux), 16'h0001});
    endtask
    // writes are taken and change nothing
    task automatic t_write;
        go(1'b1, 6'h37, 4'hF, 32'h0);
        check("wr hit", {31'h0, hit}, 32'h1);
        go(1'b1, 6'h0D, 4'hF, 32'h0);
        go(1'b0, 6'h0D, 4'hF, 32'h0000_00DC);
        go(1'b0, 6'h37, 4'hF, {word_exp(aux_power_pin), 16'h0001});
    endtask
    // partial lanes and an unmapped dword
    task automatic t_lanes;
        go(1'b0, 6'h37, 4'h1, 32'h0000_0001);
        go(1'b0, 6'h37, 4'hC, {word_exp(aux_power_pin), 16'h0});
        go(1'b0, 6'h00, 4'hF, 32'h0);
        check("miss hit", {31'h0, hit}, 32'h0);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard, far above the sixty or so cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            test_done;
        end
    end
    initial
    begin
        reset = 1'b1;
        aux_power_pin = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        reset = 1'b0;
        t_header;
        t_entry(1'b0);
        t_entry(1'b1);
        t_write;
        t_lanes;
        t_entry(1'b0);
        test_done;
    end
endmodule // pci_pm_capability_regs_tb_top
bind pci_pm_capability_regs pm_cap_checker u_chk (.clk(clk), .reset(reset), .aux_power_pin(aux_power_pin),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .aux_power_q(aux_power_q), .pm_word_q(pm_word_q));

// file: verification/pm_cap_checker.sv
// assertions on the ports of the capability register bank
`timescale 1ns/100ps
module pm_cap_checker
(
    input  wire logic                 clk,            // core clock
    input  wire logic                 reset,          // synchronous, active high
    input  wire logic                 aux_power_pin,  // raw supply level
    input  wire pm_cap_pkg::cfg_req_s cfg_req,        // request in
    input  wire pm_cap_pkg::cfg_rsp_s cfg_rsp,        // answer out
    input  wire logic                 aux_power_q,    // filtered supply
    input  wire logic [15:0]          pm_word_q       // reported word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // full-width read of one dword
    sequence rd_full(d);
        cfg_req.valid && !cfg_req.write && cfg_req.dword == d && cfg_req.byte_en == 4'hF;
    endsequence
    a_ack_follows: assert property (cfg_req.valid |=> cfg_rsp.ack) else $error("no ack");
    a_ack_single: assert property (!cfg_req.valid |=> !cfg_rsp.ack) else $error("stray ack");
    a_write_zero: assert property (cfg_req.valid && cfg_req.write |=> cfg_rsp.rdata == 32'h0) else $error("wr");
    a_cap_ptr: assert property (rd_full(6'h0D) |=> cfg_rsp.rdata == 32'h0000_00DC) else $error("ptr");
    a_bus_latency: assert property (rd_full(6'h0F) |=> cfg_rsp.rdata == 32'h1800_0000) else $error("lat");
    a_entry_head: assert property (rd_full(6'h37) |=> cfg_rsp.rdata[15:0] == 16'h0001) else $error("id");
    // the word follows the filtered level one edge later, so compare against the past level
    a_wake_mask: assert property (!$past(reset) |-> pm_word_q[15:11] == ($past(aux_power_q) ? 5'h1F : 5'h03))
        else $error("wake mask");
    a_fixed_fields: assert property (!$past(reset) |-> pm_word_q[10:0] == 11'h622) else $error("fields");
    // five equal pin samples outside reset must have reached the filtered level
    a_aux_filter: assert property (!$past(reset) && !$past(reset, 2) && !$past(reset, 3) && !$past(reset, 4)
        && aux_power_pin == $past(aux_power_pin) && aux_power_pin == $past(aux_power_pin, 2)
        && aux_power_pin == $past(aux_power_pin, 3) && aux_power_pin == $past(aux_power_pin, 4)
        |-> aux_power_q == aux_power_pin) else $error("supply filter");
endmodule // pm_cap_checker

// file: verification/pm_cfg_host.sv
// host model issuing single configuration requests
`timescale 1ns/100ps
module pm_cfg_host
(
    input  wire logic                 clk,  // core clock
    output pm_cap_pkg::cfg_req_s      req,  // request to the bank
    input  wire pm_cap_pkg::cfg_rsp_s rsp   // answer from the bank
);
    initial req = '0;
    // one request, valid for exactly one cycle, then a bounded wait for ack
    task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                          output logic [31:0] rd, output logic hit, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        req = '{1'b1, wr, dw, be, 32'hA5A5_5A5A};
        @(posedge clk);
        #1;
        // idle fields flip so a stale address can never look valid
        req = '{1'b0, ~wr, ~dw, ~be, 32'h5A5A_A5A5};
        while (rsp.ack !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = (rsp.ack === 1'b1);
        rd = rsp.rdata;
        hit = rsp.hit;
    endtask
endmodule // pm_cfg_host
